// *** csifc_pkg.sv ***
// Constants and types for the forwarding control block.
// Assumes a register port driven by the serial control bus slave on the core clock.
package csifc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_CTL_ONE = 8'h20;
    localparam logic [7:0] ADDR_CTL_TWO = 8'h21;
    localparam logic [7:0] RESET_CTL_ONE = 8'hF0;
    localparam logic [7:0] RESET_CTL_TWO = 8'h03;

    // Control one fields
    localparam int DIS_LSB = 4;
    localparam int MAP_LSB = 0;
    // Control two fields
    localparam int REPLICATE_BIT = 7;
    localparam int WHEN_PRESENT_BIT = 6;
    localparam int OUT1_MODE_LSB = 4;
    localparam int OUT0_MODE_LSB = 2;
    localparam int OUT1_BE_BIT = 1;
    localparam int OUT0_BE_BIT = 0;

    localparam int NUM_PORTS = 4;
    localparam int NUM_OUTS = 2;

    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_BASIC = 2'h1,
        MODE_INTERLEAVE = 2'h2,
        MODE_CONCAT = 2'h3
    } csifc_mode_t;

    // Register access
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csifc_reg_req_t;

    // Stream beat from a receive port
    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic isLong;
        logic [7:0] data;
    } csifc_beat_t;

    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic [1:0] port;
        logic [7:0] data;
    } csifc_out_t;

endpackage : csifc_pkg

// *** csifc_out_engine.sv ***
// Forwarding engine for one output: picks a receive port per packet.
// Assumes receive beats hold until taken (valid/ready) and packets are contiguous.
module csifc_out_engine (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Configuration, sampled at packet boundaries
    input wire logic [csifc_pkg::NUM_PORTS-1:0] member,
    input wire csifc_pkg::csifc_mode_t mode,
    input wire logic bestEffort,
    input wire logic whenPresent,
    // Receive side
    input wire csifc_pkg::csifc_beat_t [csifc_pkg::NUM_PORTS-1:0] inBeat,
    output logic [csifc_pkg::NUM_PORTS-1:0] inTake,
    // Output side
    output csifc_pkg::csifc_out_t outBeat_q
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } csifc_eng_state_t;

    csifc_eng_state_t state_q;
    logic [1:0] cur_q;
    logic [1:0] last_q;
    logic [csifc_pkg::NUM_PORTS-1:0] present;
    logic [csifc_pkg::NUM_PORTS-1:0] longPresent;
    logic allPresent;
    logic pickOk;
    logic [1:0] pick;
    logic [csifc_pkg::NUM_PORTS-1:0] served_q;
    logic [csifc_pkg::NUM_PORTS-1:0] longPass;
    logic [csifc_pkg::NUM_PORTS-1:0] cand;
    logic syncOn;
    logic asAvail;

    genvar gi;
    generate
        for (gi = 0; gi < csifc_pkg::NUM_PORTS; gi++) begin : g_pres
            assign present[gi] = member[gi] & inBeat[gi].valid & inBeat[gi].sop;
            assign longPresent[gi] = present[gi] & inBeat[gi].isLong;
        end
    endgenerate

    assign syncOn = !bestEffort && (mode != csifc_pkg::MODE_OFF);
    assign asAvail = whenPresent && (mode != csifc_pkg::MODE_CONCAT);
    assign longPass = asAvail ? longPresent : '0;
    // A port already served this round waits, unless its line may go as available
    assign cand = syncOn ? (present & ~(served_q & ~longPass)) : present;

    assign allPresent = (member != '0) && (((present | served_q) & member) == member);

    // round of one line per member; without it the second port of a round would starve
    always_ff @(posedge clock) begin
        if (!resetn) begin
            served_q <= '0;
        end else if (!syncOn || ((served_q & member) == member)) begin
            served_q <= '0;
        end else if (state_q == ST_SEND && inBeat[cur_q].valid && inBeat[cur_q].eop) begin
            served_q[cur_q] <= 1'b1;
        end
    end

    always_comb begin
        logic [2:0] idx;
        pick = last_q;
        pickOk = 1'b0;
        idx = '0;
        for (int k = 1; k <= csifc_pkg::NUM_PORTS; k++) begin
            idx = 3'(({1'b0, last_q} + 3'(k)) & 3'h3);
            if (!pickOk && cand[idx[1:0]]) begin
                pick = idx[1:0];
                pickOk = 1'b1;
            end
        end
        if (bestEffort) begin
            pickOk = pickOk;
        end else if (mode == csifc_pkg::MODE_OFF) begin
            pickOk = 1'b0;
        // short packets and concatenation still wait
        end else if (whenPresent && mode != csifc_pkg::MODE_CONCAT && longPresent[pick]) begin
            pickOk = pickOk;
        end else begin
            pickOk = pickOk & allPresent;
        end
    end

    always_comb begin
        inTake = '0;
        if (state_q == ST_SEND) begin
            inTake[cur_q] = inBeat[cur_q].valid;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            cur_q <= 2'h0;
            last_q <= 2'h3;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (pickOk) begin
                        cur_q <= pick;
                        state_q <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (inBeat[cur_q].valid && inBeat[cur_q].eop) begin
                        last_q <= cur_q;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            outBeat_q <= '0;
        end else begin
            outBeat_q.valid <= (state_q == ST_SEND) & inBeat[cur_q].valid;
            outBeat_q.sop <= inBeat[cur_q].sop;
            outBeat_q.eop <= inBeat[cur_q].eop;
            outBeat_q.port <= cur_q;
            outBeat_q.data <= inBeat[cur_q].data;
        end
    end

endmodule : csifc_out_engine

// *** csifc_forwarding_control.sv ***
// Forwarding control: two control registers and the routing of receive ports onto two outputs.
// Assumes the serial control bus slave presents one-cycle read/write strobes on the core clock.
//
// Contract
// - Map bit per receive port 0..3: 0 sends to output 0, 1 to output 1.
// - Replicate bit 7 set: output 1 carries exactly output 0's stream.
// - Synchronized without as-available: hold line until every enabled port has data; the code waits only for enabled ports mapped to that output.
// - As-available bit 6 set: send each port's line once it is present.
// - As-available affects only long packets and nothing in concatenation mode.
// - One as-available bit governs both outputs together.
// - Output 1 mode bits 5:4: off, basic, interleave, concatenation.
// - Output 0 mode bits 3:2 use the same encoding independently.
// - Best-effort does not synchronize; waiting ports served roughly round-robin.
// - Per-port disable bit: 1 stops forwarding, 0 allows it.
module csifc_forwarding_control (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port
    input wire csifc_pkg::csifc_reg_req_t regReq,
    output logic [7:0] regRdata_q,
    // Receive ports
    input wire csifc_pkg::csifc_beat_t [csifc_pkg::NUM_PORTS-1:0] rxBeat,
    output logic [csifc_pkg::NUM_PORTS-1:0] rxTake,
    // Outputs
    output csifc_pkg::csifc_out_t out0Beat_q,
    output csifc_pkg::csifc_out_t out1Beat_q
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] ctlOne_q;
    logic [7:0] ctlTwo_q;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ctlOne_q <= csifc_pkg::RESET_CTL_ONE;
            ctlTwo_q <= csifc_pkg::RESET_CTL_TWO;
        end else if (regReq.write) begin
            if (regReq.addr == csifc_pkg::ADDR_CTL_ONE) begin
                ctlOne_q <= regReq.wdata;
            end
            if (regReq.addr == csifc_pkg::ADDR_CTL_TWO) begin
                ctlTwo_q <= regReq.wdata;
            end
        end
    end

    // Unmapped addresses read as zero
    always_ff @(posedge clock) begin
        if (!resetn) begin
            regRdata_q <= 8'h00;
        end else if (regReq.read) begin
            case (regReq.addr)
                csifc_pkg::ADDR_CTL_ONE: regRdata_q <= ctlOne_q;
                csifc_pkg::ADDR_CTL_TWO: regRdata_q <= ctlTwo_q;
                default: regRdata_q <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Routing
    // ****************************************
    logic [csifc_pkg::NUM_PORTS-1:0] enabled;
    logic [csifc_pkg::NUM_PORTS-1:0] memberZero;
    logic [csifc_pkg::NUM_PORTS-1:0] memberOne;
    logic [csifc_pkg::NUM_PORTS-1:0] takeZero;
    logic [csifc_pkg::NUM_PORTS-1:0] takeOne;
    logic replicate;
    csifc_pkg::csifc_out_t eng0Beat;
    csifc_pkg::csifc_out_t eng1Beat;

    // Replicate is read live; a flip mid-packet could split a frame, so software flips it while idle
    assign replicate = ctlTwo_q[csifc_pkg::REPLICATE_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < csifc_pkg::NUM_PORTS; gi++) begin : g_map
            assign enabled[gi] = ~ctlOne_q[csifc_pkg::DIS_LSB + gi];
            assign memberZero[gi] = enabled[gi] & (replicate | ~ctlOne_q[csifc_pkg::MAP_LSB + gi]);
            assign memberOne[gi] = enabled[gi] & ~replicate & ctlOne_q[csifc_pkg::MAP_LSB + gi];
        end
    endgenerate

    csifc_out_engine u_eng0 (
        .clock(clock),
        .resetn(resetn),
        .member(memberZero),
        .mode(csifc_pkg::csifc_mode_t'(ctlTwo_q[csifc_pkg::OUT0_MODE_LSB +: 2])),
        .bestEffort(ctlTwo_q[csifc_pkg::OUT0_BE_BIT]),
        .whenPresent(ctlTwo_q[csifc_pkg::WHEN_PRESENT_BIT]),
        .inBeat(rxBeat),
        .inTake(takeZero),
        .outBeat_q(eng0Beat)
    );

    csifc_out_engine u_eng1 (
        .clock(clock),
        .resetn(resetn),
        .member(memberOne),
        .mode(csifc_pkg::csifc_mode_t'(ctlTwo_q[csifc_pkg::OUT1_MODE_LSB +: 2])),
        .bestEffort(ctlTwo_q[csifc_pkg::OUT1_BE_BIT]),
        .whenPresent(ctlTwo_q[csifc_pkg::WHEN_PRESENT_BIT]),
        .inBeat(rxBeat),
        .inTake(takeOne),
        .outBeat_q(eng1Beat)
    );

    assign rxTake = takeZero | takeOne;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            out0Beat_q <= '0;
            out1Beat_q <= '0;
        end else begin
            out0Beat_q <= eng0Beat;
            out1Beat_q <= replicate ? eng0Beat : eng1Beat;
        end
    end

endmodule : csifc_forwarding_control

// *** csifc_forwarding_control_properties.sv ***
// Port checker for the forwarding control block.
// Assumes software writes only while every stream is idle.
module csifc_forwarding_control_properties (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port
    input wire csifc_pkg::csifc_reg_req_t regReq,
    input wire logic [7:0] regRdata_q,
    // Streams
    input wire csifc_pkg::csifc_beat_t [csifc_pkg::NUM_PORTS-1:0] rxBeat,
    input wire logic [csifc_pkg::NUM_PORTS-1:0] rxTake,
    input wire csifc_pkg::csifc_out_t out0Beat_q,
    input wire csifc_pkg::csifc_out_t out1Beat_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [7:0] one_q;
    logic [7:0] two_q;
    logic [2:0] calm_q;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            one_q <= csifc_pkg::RESET_CTL_ONE;
            two_q <= csifc_pkg::RESET_CTL_TWO;
        end else if (regReq.write) begin
            if (regReq.addr == csifc_pkg::ADDR_CTL_ONE) one_q <= regReq.wdata;
            if (regReq.addr == csifc_pkg::ADDR_CTL_TWO) two_q <= regReq.wdata;
        end
    end
    // Engines decide a few cycles ahead, so settings count only once settled
    always_ff @(posedge clock) begin
        if (!resetn || regReq.write) calm_q <= 3'h0;
        else if (calm_q != 3'h7) calm_q <= calm_q + 3'h1;
    end
    property p_read_one;
        regReq.read && !regReq.write && regReq.addr == csifc_pkg::ADDR_CTL_ONE |=> regRdata_q == $past(one_q);
    endproperty
    a_read_one: assert property (p_read_one)
        else $error("control one readback wrong");
    property p_read_two;
        regReq.read && !regReq.write && regReq.addr == csifc_pkg::ADDR_CTL_TWO |=> regRdata_q == $past(two_q);
    endproperty
    a_read_two: assert property (p_read_two)
        else $error("control two readback wrong");
    property p_read_other;
        regReq.read && regReq.addr != csifc_pkg::ADDR_CTL_ONE && regReq.addr != csifc_pkg::ADDR_CTL_TWO
            |=> regRdata_q == 8'h00;
    endproperty
    a_read_other: assert property (p_read_other)
        else $error("unmapped read not zero");
    property p_copy;
        calm_q == 3'h7 && two_q[csifc_pkg::REPLICATE_BIT] |-> out1Beat_q == out0Beat_q;
    endproperty
    a_copy: assert property (p_copy)
        else $error("output one differs from output zero");
    property p_route;
        calm_q == 3'h7 && out0Beat_q.valid && out0Beat_q.sop
            |-> !one_q[out0Beat_q.port] && !one_q[csifc_pkg::DIS_LSB + out0Beat_q.port];
    endproperty
    a_route: assert property (p_route)
        else $error("packet from unmapped or disabled port");
    property p_off0;
        calm_q == 3'h7 && two_q[csifc_pkg::OUT0_MODE_LSB +: 2] == 2'h0 && !two_q[csifc_pkg::OUT0_BE_BIT]
            |-> !out0Beat_q.valid;
    endproperty
    a_off0: assert property (p_off0)
        else $error("output zero sends while off");
    property p_off1;
        calm_q == 3'h7 && two_q[csifc_pkg::OUT1_MODE_LSB +: 2] == 2'h0 && !two_q[csifc_pkg::OUT1_BE_BIT]
            && !two_q[csifc_pkg::REPLICATE_BIT] |-> !out1Beat_q.valid;
    endproperty
    a_off1: assert property (p_off1)
        else $error("output one sends while off");
    property p_latency;
        rxTake[0] |-> ##2 ((out0Beat_q.valid && out0Beat_q.data == $past(rxBeat[0].data, 2))
            || (out1Beat_q.valid && out1Beat_q.data == $past(rxBeat[0].data, 2)));
    endproperty
    a_latency: assert property (p_latency)
        else $error("taken beat not forwarded intact");
    property p_whole;
        out0Beat_q.valid && !out0Beat_q.eop |=> out0Beat_q.valid;
    endproperty
    a_whole: assert property (p_whole)
        else $error("packet broken on output zero");
endmodule : csifc_forwarding_control_properties

// *** csifc_sink_model.sv ***
// Downstream receiver: counts beats arriving on each output.
// Assumes outputs never stall, as the block has no ready input.
module csifc_sink_model (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Output beats
    input wire csifc_pkg::csifc_out_t beatZero,
    input wire csifc_pkg::csifc_out_t beatOne,
    // Counts
    output logic [15:0] countZero_q,
    output logic [15:0] countOne_q
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            countZero_q <= 16'h0000;
            countOne_q <= 16'h0000;
        end else begin
            countZero_q <= countZero_q + 16'(beatZero.valid);
            countOne_q <= countOne_q + 16'(beatOne.valid);
        end
    end
endmodule : csifc_sink_model

// *** csifc_forwarding_control_test.sv ***
// Testbench: register accesses and packet traffic through the forwarding block.
// Assumes three-beat packets and a sink that counts output beats.
module csifc_forwarding_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock;
    logic resetn;
    csifc_pkg::csifc_reg_req_t regReq;
    logic [7:0] regRdata_q;
    csifc_pkg::csifc_beat_t [csifc_pkg::NUM_PORTS-1:0] rxBeat;
    logic [csifc_pkg::NUM_PORTS-1:0] rxTake;
    csifc_pkg::csifc_out_t out0Beat_q;
    csifc_pkg::csifc_out_t out1Beat_q;
    logic [15:0] count0;
    logic [15:0] count1;
    logic [15:0] b0;
    logic [15:0] b1;
    int fail_count = 0;
    int check_count = 0;
    // Modes with best-effort cleared whenever synchronized is set
    logic [7:0] tabOne [11] = '{8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'hC3, 8'hC3, 8'hC3, 8'hC3};
    logic [7:0] tabTwo [11] = '{8'h01, 8'h04, 8'h08, 8'h0C, 8'h44, 8'h44, 8'h4C, 8'h50, 8'h10, 8'h20, 8'h30};
    logic [10:0] tabLong = 11'b11111011111;
    logic [10:0] tabWait = 11'b11101101110;
    csifc_forwarding_control dut (.clock(clock), .resetn(resetn), .regReq(regReq), .regRdata_q(regRdata_q),
        .rxBeat(rxBeat), .rxTake(rxTake), .out0Beat_q(out0Beat_q), .out1Beat_q(out1Beat_q));
    csifc_sink_model sink (.clock(clock), .resetn(resetn), .beatZero(out0Beat_q), .beatOne(out1Beat_q),
        .countZero_q(count0), .countOne_q(count1));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regReq = '{1'b1, 1'b0, a, d};
        tick(1);
        regReq = '0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regReq = '{1'b0, 1'b1, a, 8'h00};
        tick(1);
        chk({8'h00, regRdata_q}, {8'h00, exp});
        regReq = '0;
        tick(1);
    endtask : rd
    // Each beat is held until the block takes it
    task automatic send(input int p, input logic lng);
        int n;
        for (int i = 0; i < 3; i++) begin
            rxBeat[p] = '{1'b1, i == 0, i == 2, lng, 8'(16 * p + i)};
            n = 0;
            while (!rxTake[p] && n < 200) begin
                tick(1);
                n++;
            end
            chk({15'h0000, rxTake[p]}, 16'h0001);
            tick(1);
        end
        rxBeat[p] = '0;
    endtask : send
    task automatic sync_case(input int r);
        logic sel;
        sel = tabOne[r][0];
        wr(csifc_pkg::ADDR_CTL_ONE, 8'hF0 | tabOne[r]);
        wr(csifc_pkg::ADDR_CTL_ONE, tabOne[r]);
        wr(csifc_pkg::ADDR_CTL_TWO, tabTwo[r]);
        rd(csifc_pkg::ADDR_CTL_TWO, tabTwo[r]);
        b0 = sel ? count1 : count0;
        fork
            send(0, tabLong[r]);
            begin
                tick(20);
                chk((sel ? count1 : count0) - b0, tabWait[r] ? 16'h0000 : 16'h0003);
                send(1, tabLong[r]);
            end
        join
        tick(8);
        chk((sel ? count1 : count0) - b0, 16'h0006);
    endtask : sync_case
    task automatic stop_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        #200us;
        fail_count++;
        stop_test();
    end
    initial begin
        regReq = '0;
        rxBeat = '0;
        resetn = 1'b0;
        tick(20);
        resetn = 1'b1;
        rd(csifc_pkg::ADDR_CTL_ONE, csifc_pkg::RESET_CTL_ONE);
        rd(csifc_pkg::ADDR_CTL_TWO, csifc_pkg::RESET_CTL_TWO);
        rd(8'h22, 8'h00);
        wr(csifc_pkg::ADDR_CTL_ONE, 8'hC2);
        b0 = count0;
        b1 = count1;
        fork
            send(0, 1'b1);
            send(1, 1'b1);
            rxBeat[2] = '{1'b1, 1'b1, 1'b1, 1'b1, 8'h20};
        join
        tick(20);
        chk(count0 - b0, 16'h0003);
        chk(count1 - b1, 16'h0003);
        rxBeat[2] = '0;
        wr(csifc_pkg::ADDR_CTL_TWO, 8'h81);
        b1 = count1;
        send(0, 1'b1);
        tick(8);
        chk(count1 - b1, 16'h0003);
        for (int r = 0; r < 11; r++) begin
            sync_case(r);
        end
        stop_test();
    end
endmodule : csifc_forwarding_control_test
bind csifc_forwarding_control csifc_forwarding_control_properties u_props (.clock(clock), .resetn(resetn),
    .regReq(regReq), .regRdata_q(regRdata_q), .rxBeat(rxBeat), .rxTake(rxTake),
    .out0Beat_q(out0Beat_q), .out1Beat_q(out1Beat_q));
